/* inc/adcseq_regs.vh */
/*
  Register map, field positions, reset values and timing counts of the converter sequencer.
  Assumes a 25 MHz clk; included by the sequencer design file.
*/
`ifndef ADCSEQ_REGS_VH
`define ADCSEQ_REGS_VH

// Register byte addresses on the AXI4-Lite bus
`define ADCSEQ_ADDR_PRIMARY     8'h00
`define ADCSEQ_ADDR_PORTCFG     8'h04
`define ADCSEQ_ADDR_RES_HIGH    8'h08
`define ADCSEQ_ADDR_RES_LOW     8'h0c
`define ADCSEQ_ADDR_STATUS      8'h10
`define ADCSEQ_IDX_ACQ_CTRL     8'h9b
`define ADCSEQ_ADDR_ACQ_CTRL    10'h26c

// converter_control_primary fields
`define ADCSEQ_PRI_ON_BIT       0
`define ADCSEQ_PRI_GO_BIT       2
`define ADCSEQ_PRI_CHS_LSB      3
`define ADCSEQ_PRI_CHS_MSB      5
`define ADCSEQ_PRI_CS_LSB       6
`define ADCSEQ_PRI_CS_MSB       7
`define ADCSEQ_PRI_RESET        8'h00

// converter_port_config fields
`define ADCSEQ_CFG_PCFG_LSB     0
`define ADCSEQ_CFG_PCFG_MSB     3
`define ADCSEQ_CFG_VREFP_BIT    4
`define ADCSEQ_CFG_VREFN_BIT    5
`define ADCSEQ_CFG_CS2_BIT      6
`define ADCSEQ_CFG_RESET        8'h00

// acquisition_time_control fields
`define ADCSEQ_ACQ_LSB          3
`define ADCSEQ_ACQ_MSB          5
`define ADCSEQ_ACQ_MASK         8'h38
`define ADCSEQ_ACQ_RESET        8'h00

// Status register: conversion_done_flag, write one to clear
`define ADCSEQ_STS_DONE_BIT     0

// Timing, in conversion bit periods
`define ADCSEQ_CONV_TAD         12
`define ADCSEQ_GAP_TAD          2
`define ADCSEQ_RESULT_BITS      10

// Clock and instruction cycle, in ns
`define ADCSEQ_CLK_PERIOD_NS    40
`define ADCSEQ_INSN_CYCLE_NS    160
`define ADCSEQ_INSN_CYCLES      (`ADCSEQ_INSN_CYCLE_NS / `ADCSEQ_CLK_PERIOD_NS)

`endif

/* design/adcseq_top.v */
/*
  Acquisition and conversion sequencer of a 10-bit SAR converter, with AXI4-Lite registers.
  Assumes an external comparator answering each trial code one clk later, and an RC
  oscillator tick input that is synchronous to clk.
*/
// Function
// [RULE_01] Acquisition-time field bits 5..3 selects 0,2,4,6,8,12,16,20 bit periods.
// [RULE_02] With RC clock source, one instruction cycle passes before the bit clock starts.
// [RULE_03] Bits 7..6 and 2..0 of acquisition control read zero.
// [RULE_04] Reset restores registers, turns converter off, aborts conversion.
// [RULE_05] At completion: load result, clear start flag, set done flag together.
// [RULE_06] Result registers have no reset; undefined until conversion or write.
// [RULE_07] After conversion wait two bit periods, hold capacitor disconnected.
// [RULE_08] Acquisition code zero: start flag begins conversion immediately.
// [RULE_09] Software ensures acquisition time before start when code is zero.
// [RULE_10] Nonzero code: keep sampling for programmed periods, then convert.
// [RULE_11] After every conversion resume sampling selected channel.
// [RULE_12] No status shows acquisition end or conversion begin, only start flag.
// [RULE_13] Result by successive approximation, 1024 steps; the code resolves it in 10 steps, one trial bit per period.
// [RULE_14] Sleep conversion only with RC clock; software selects it before sleep.
// [RULE_15] Software configures pins, reference, channel, times, then turns converter on.
// [RULE_16] Software clears done flag then sets interrupt enables for completion interrupt.
// [RULE_17] Software polls start flag or takes interrupt, reads results, clears done.
// [RULE_18] Reference selectable: supply rails or external reference pins.
// [RULE_19] Clearing start flag mid-conversion aborts; result registers keep old value.
// [RULE_20] A 10-bit conversion takes at least twelve bit periods.
// [RULE_21] Clock select gives 2,4,8,16,32,64 periods; x11 selects RC oscillator.
// [RULE_22] Acquisition counts bit periods; start flag set until conversion completes.
// [RULE_23] Acquisition field resets to 000.
`include "adcseq_regs.vh"
`timescale 1ns/100ps
`default_nettype none

module adcseq_top #(
  parameter ADDR_W = 12
) (
  input  wire              clk,
  input  wire              rst_n,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire              rc_osc_tick,
  input  wire              cmp_above,
  output reg  [9:0]        sar_code_q,
  output reg               sample_switch_q,
  output reg               converter_on_q,
  output reg  [2:0]        channel_sel_q,
  output reg               vref_pos_ext_q,
  output reg               vref_neg_ext_q,
  output reg  [3:0]        pin_analog_cfg_q,
  output reg               conversion_done_flag_q
);

  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_DLY  = 5'h02;
  localparam [4:0] ST_ACQ  = 5'h04;
  localparam [4:0] ST_CONV = 5'h08;
  localparam [4:0] ST_GAP  = 5'h10;
  localparam integer INSN_CYC_I = `ADCSEQ_INSN_CYCLES;
  localparam [2:0] INSN_CYC = INSN_CYC_I[2:0];

  reg  [7:0] primary_q;
  reg  [7:0] portcfg_q;
  reg  [7:0] acq_ctrl_q;
  reg  [9:0] result_q;
  reg        go_q;
  reg  [4:0] state_q;
  reg  [5:0] div_q;
  reg  [4:0] tad_cnt_q;
  reg  [3:0] bit_q;
  reg  [2:0] dly_q;
  reg        aw_hold_q;
  reg        w_hold_q;
  reg  [ADDR_W-1:0] awaddr_q;
  reg  [31:0] wdata_q;
  reg  [3:0] wstrb_q;

  wire [2:0] clk_sel = {portcfg_q[`ADCSEQ_CFG_CS2_BIT],
                        primary_q[`ADCSEQ_PRI_CS_MSB:`ADCSEQ_PRI_CS_LSB]};
  wire       use_rc  = (clk_sel[1:0] == 2'b11); // RULE_21
  wire [2:0] acq_sel = acq_ctrl_q[`ADCSEQ_ACQ_MSB:`ADCSEQ_ACQ_LSB];

  // Divider terminal count per clock select
  reg  [5:0] div_last;
  always @* begin
    case ({clk_sel[2], clk_sel[1:0]}) // RULE_21
      3'b000:  div_last = 6'h01;
      3'b100:  div_last = 6'h03;
      3'b001:  div_last = 6'h07;
      3'b101:  div_last = 6'h0f;
      3'b010:  div_last = 6'h1f;
      3'b110:  div_last = 6'h3f;
      default: div_last = 6'h00;
    endcase
  end

  // Acquisition length in bit periods
  reg  [4:0] acq_tads;
  always @* begin
    case (acq_sel) // RULE_01
      3'h0:    acq_tads = 5'h00;
      3'h1:    acq_tads = 5'h02;
      3'h2:    acq_tads = 5'h04;
      3'h3:    acq_tads = 5'h06;
      3'h4:    acq_tads = 5'h08;
      3'h5:    acq_tads = 5'h0c;
      3'h6:    acq_tads = 5'h10;
      default: acq_tads = 5'h14;
    endcase
  end

  wire tad_tick = use_rc ? rc_osc_tick : (div_q == div_last);

  // Bus decode: a write acts only once both halves are captured, never on a pending offer
  wire        wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
  wire [ADDR_W-1:0] wa = awaddr_q;
  wire [31:0] wd = wdata_q;
  wire        wb0 = wstrb_q[0];
  wire        wr_lane = wr_fire && wb0;
  wire        wr_pri  = wr_lane && (wa == `ADCSEQ_ADDR_PRIMARY);
  wire        wr_cfg  = wr_lane && (wa == `ADCSEQ_ADDR_PORTCFG);
  wire        wr_acq  = wr_lane && (wa == `ADCSEQ_ADDR_ACQ_CTRL);
  wire        wr_resh = wr_lane && (wa == `ADCSEQ_ADDR_RES_HIGH);
  wire        wr_resl = wr_lane && (wa == `ADCSEQ_ADDR_RES_LOW);
  wire        wr_sts  = wr_lane && (wa == `ADCSEQ_ADDR_STATUS);
  wire        wr_ok   = (wa == `ADCSEQ_ADDR_PRIMARY) || (wa == `ADCSEQ_ADDR_PORTCFG) ||
                        (wa == `ADCSEQ_ADDR_ACQ_CTRL) || (wa == `ADCSEQ_ADDR_RES_HIGH) ||
                        (wa == `ADCSEQ_ADDR_RES_LOW) || (wa == `ADCSEQ_ADDR_STATUS);

  wire        go_set  = wr_pri && wd[`ADCSEQ_PRI_GO_BIT] && !go_q && wd[`ADCSEQ_PRI_ON_BIT] &&
                        primary_q[`ADCSEQ_PRI_ON_BIT];
  wire        go_clr  = wr_pri && !wd[`ADCSEQ_PRI_GO_BIT];
  wire        conv_end = (state_q == ST_CONV) && tad_tick &&
                         (tad_cnt_q == 5'd`ADCSEQ_CONV_TAD - 5'd1);

  reg  [31:0] rd_word;
  reg         rd_ok;
  always @* begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `ADCSEQ_ADDR_PRIMARY:  rd_word = {24'h0, primary_q[7:3], go_q, 1'b0, // RULE_12
                                        primary_q[0]};
      `ADCSEQ_ADDR_PORTCFG:  rd_word = {24'h0, 1'b0, portcfg_q[6:0]};
      `ADCSEQ_ADDR_ACQ_CTRL: rd_word = {24'h0, acq_ctrl_q & `ADCSEQ_ACQ_MASK}; // RULE_03
      `ADCSEQ_ADDR_RES_HIGH: rd_word = {30'h0, result_q[9:8]};
      `ADCSEQ_ADDR_RES_LOW:  rd_word = {24'h0, result_q[7:0]};
      `ADCSEQ_ADDR_STATUS:   rd_word = {31'h0, conversion_done_flag_q};
      default: begin
        rd_word = 32'h0;
        rd_ok   = 1'b0;
      end
    endcase
  end

  // Result registers carry no reset so power-up content stays undefined
  always @(posedge clk) begin
    if (rst_n && conv_end && go_q && !go_clr) begin
      result_q <= sar_code_q; // RULE_05 RULE_06
    end else begin
      if (wr_resh) result_q[9:8] <= wd[1:0];
      if (wr_resl) result_q[7:0] <= wd[7:0];
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin // RULE_04
      primary_q <= `ADCSEQ_PRI_RESET;
      portcfg_q <= `ADCSEQ_CFG_RESET;
      acq_ctrl_q <= `ADCSEQ_ACQ_RESET; // RULE_23
      go_q <= 1'b0;
      conversion_done_flag_q <= 1'b0;
      state_q <= ST_IDLE;
      div_q <= 6'h00;
      tad_cnt_q <= 5'h00;
      bit_q <= 4'h0;
      dly_q <= 3'h0;
      sar_code_q <= 10'h000;
      sample_switch_q <= 1'b0;
      converter_on_q <= 1'b0;
      channel_sel_q <= 3'h0;
      vref_pos_ext_q <= 1'b0;
      vref_neg_ext_q <= 1'b0;
      pin_analog_cfg_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h0;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= {ADDR_W{1'b0}};
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else begin
      // Write channel: capture address and data in either order
      s_axi_awready <= !aw_hold_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_hold_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (aw_hold_q && w_hold_q && !s_axi_bvalid) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // Read channel
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end

      if (aw_hold_q && w_hold_q && !s_axi_bvalid) begin
        if (wr_pri) primary_q <= wd[7:0] & 8'hfb;
        if (wr_cfg) portcfg_q <= wd[7:0] & 8'h7f;
        if (wr_acq) acq_ctrl_q <= wd[7:0] & `ADCSEQ_ACQ_MASK; // RULE_03
      end

      converter_on_q <= primary_q[`ADCSEQ_PRI_ON_BIT];
      channel_sel_q <= primary_q[`ADCSEQ_PRI_CHS_MSB:`ADCSEQ_PRI_CHS_LSB];
      vref_pos_ext_q <= portcfg_q[`ADCSEQ_CFG_VREFP_BIT]; // RULE_18
      vref_neg_ext_q <= portcfg_q[`ADCSEQ_CFG_VREFN_BIT]; // RULE_18
      pin_analog_cfg_q <= portcfg_q[`ADCSEQ_CFG_PCFG_MSB:`ADCSEQ_CFG_PCFG_LSB];

      // Done flag: the hardware set wins over a simultaneous clear
      if (conv_end && go_q && !go_clr)
        conversion_done_flag_q <= 1'b1; // RULE_05
      else if (wr_sts && wd[`ADCSEQ_STS_DONE_BIT])
        conversion_done_flag_q <= 1'b0;

      // Start flag stays set through acquisition and conversion
      if (go_set && wr_fire && aw_hold_q && w_hold_q)
        go_q <= 1'b1; // RULE_22
      else if ((go_clr && aw_hold_q && w_hold_q && !s_axi_bvalid) || conv_end ||
               !primary_q[`ADCSEQ_PRI_ON_BIT])
        go_q <= 1'b0; // RULE_05 RULE_19

      div_q <= (tad_tick || state_q == ST_IDLE) ? 6'h00 : div_q + 6'h01;

      case (state_q)
        ST_IDLE: begin
          sample_switch_q <= primary_q[`ADCSEQ_PRI_ON_BIT]; // RULE_11
          tad_cnt_q <= 5'h00;
          if (go_q) begin
            dly_q <= 3'h0;
            if (use_rc) begin
              state_q <= ST_DLY; // RULE_02 RULE_14
            end else if (acq_tads == 5'h00) begin
              sample_switch_q <= 1'b0; // RULE_08
              bit_q <= 4'd9;
              sar_code_q <= 10'h200;
              state_q <= ST_CONV;
            end else begin
              state_q <= ST_ACQ; // RULE_10
            end
          end
        end
        ST_DLY: begin
          // Start on an RC period boundary so the first period is whole and the trial code settled
          if (dly_q != INSN_CYC - 3'h1) dly_q <= dly_q + 3'h1;
          if (!go_q) begin
            state_q <= ST_IDLE;
          end else if (dly_q == INSN_CYC - 3'h1 && tad_tick) begin // RULE_02
            if (acq_tads == 5'h00) begin
              sample_switch_q <= 1'b0;
              bit_q <= 4'd9;
              sar_code_q <= 10'h200;
              state_q <= ST_CONV;
            end else begin
              state_q <= ST_ACQ;
            end
          end
        end
        ST_ACQ: begin
          if (!go_q) begin
            state_q <= ST_IDLE;
          end else if (tad_tick) begin
            if (tad_cnt_q == acq_tads - 5'h01) begin // RULE_10 RULE_22
              tad_cnt_q <= 5'h00;
              sample_switch_q <= 1'b0;
              bit_q <= 4'd9;
              sar_code_q <= 10'h200;
              state_q <= ST_CONV;
            end else begin
              tad_cnt_q <= tad_cnt_q + 5'h01;
            end
          end
        end
        ST_CONV: begin
          if (!go_q) begin
            tad_cnt_q <= 5'h00;
            state_q <= ST_GAP; // RULE_19
          end else if (tad_tick) begin
            tad_cnt_q <= tad_cnt_q + 5'h01;
            // One trial bit per period during the first ten periods
            if (tad_cnt_q < 5'd`ADCSEQ_RESULT_BITS) begin // RULE_13
              if (!cmp_above) sar_code_q[bit_q] <= 1'b0;
              if (bit_q != 4'h0) begin
                sar_code_q[bit_q - 4'h1] <= 1'b1;
                bit_q <= bit_q - 4'h1;
              end
            end
            if (conv_end) begin // RULE_20
              tad_cnt_q <= 5'h00;
              state_q <= ST_GAP;
            end
          end
        end
        ST_GAP: begin
          sample_switch_q <= 1'b0; // RULE_07
          if (tad_tick) begin
            if (tad_cnt_q == 5'd`ADCSEQ_GAP_TAD - 5'd1) begin
              tad_cnt_q <= 5'h00;
              state_q <= ST_IDLE; // RULE_11
            end else begin
              tad_cnt_q <= tad_cnt_q + 5'h01;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
      if (!primary_q[`ADCSEQ_PRI_ON_BIT]) sample_switch_q <= 1'b0; // RULE_04
    end
  end

endmodule // adcseq_top

`default_nettype wire

/* bench/adcseq_top_asserts.sv */
/*
  Port checks of the sequencer top, bound to it from the bench.
  Assumes one clk domain with synchronous active-low rst_n.
*/
`timescale 1ns/100ps
`default_nettype none
module adcseq_top_asserts (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        sample_switch_q,
  input wire logic        converter_on_q,
  input wire logic        conversion_done_flag_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Shortest gap is two bit periods of two clk each
  a_gap_open: assert property
    ($rose(conversion_done_flag_q) |-> !sample_switch_q [*4]) else $error("Early resample");
  a_resample: assert property
    ($rose(conversion_done_flag_q) && converter_on_q |-> ##[1:300] sample_switch_q)
    else $error("Sampling did not resume");
  a_reset_off: assert property
    (disable iff (1'b0) !rst_n |=> !converter_on_q && !sample_switch_q && !conversion_done_flag_q)
    else $error("Reset left converter active");
  a_on_sample: assert property
    (sample_switch_q |-> converter_on_q) else $error("Sampling while off");
  a_conv_long: assert property
    ($rose(conversion_done_flag_q) |-> !$past(sample_switch_q, 23)) else $error("Short conversion");
  a_done_on: assert property
    ($rose(conversion_done_flag_q) |-> converter_on_q) else $error("Done while off");
  a_b_hold: assert property
    (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped");
  a_r_hold: assert property
    (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data dropped");
  c_done: cover property ($rose(conversion_done_flag_q));
  c_hold: cover property ($fell(sample_switch_q));
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule // adcseq_top_asserts
`default_nettype wire

/* bench/adcseq_analog_model.sv */
/*
  Analog side of the sequencer: sample-and-hold, comparator and RC bit clock.
  Assumes the sequencer reads cmp_above one clk after each trial code.
*/
`timescale 1ns/100ps
`default_nettype none
module adcseq_analog_model #(
  parameter int RC_DIV = 10
) (
  input  wire logic       clk,
  input  wire logic [9:0] vin,
  input  wire logic [9:0] sar_code_q,
  input  wire logic       sample_switch_q,
  output var  logic       cmp_above,
  output var  logic       rc_osc_tick
);
  logic [9:0] held = 10'h000;
  int         div = 0;
  // Held value freezes while disconnected, so an early reconnect corrupts the result
  always @(posedge clk) begin
    if (sample_switch_q) held <= vin;
    cmp_above <= held >= sar_code_q;
    div <= (div == RC_DIV - 1) ? 0 : div + 1;
    rc_osc_tick <= div == 0;
  end
endmodule // adcseq_analog_model
`default_nettype wire

/* bench/tb_adcseq_top.sv */
/*
  Self-checking bench of the sequencer: a table of conversions, then bus error,
  abort and reset cases. Assumes the analog model and the bound checker.
*/
`include "adcseq_regs.vh"
`timescale 1ns/100ps
`default_nettype none
module tb_adcseq_top;
  typedef struct packed {logic [2:0] acq; logic [2:0] cs; logic [9:0] vin; int bitp;} adcseq_row_t;
  localparam int RC_DIV = 10;
  localparam int ACQ_BITS [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  adcseq_row_t rows [8] = '{'{3'd0, 3'b000, 10'h000, 2}, '{3'd1, 3'b100, 10'h3ff, 4},
    '{3'd2, 3'b001, 10'h155, 8}, '{3'd3, 3'b101, 10'h2aa, 16},
    '{3'd4, 3'b010, 10'h200, 32}, '{3'd5, 3'b110, 10'h1ff, 64},
    '{3'd6, 3'b011, 10'h001, RC_DIV}, '{3'd7, 3'b111, 10'h3fe, RC_DIV}};
  logic        clk = 1'b0, rst_n = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rd_q;
  logic [9:0]  vin = 10'h000;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  resp_q;
  wire         awready, wready, bvalid, arready, rvalid, cmp, tick, sw, on, done, vpos, vneg;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [9:0]  code;
  wire  [2:0]  chan;
  wire  [3:0]  pcfg;
  int          n_fail = 0, check_count = 0, cyc = 0, t, lo, hi;
  adcseq_row_t r;

  adcseq_top DUT (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rc_osc_tick(tick), .cmp_above(cmp), .sar_code_q(code), .sample_switch_q(sw),
    .converter_on_q(on), .channel_sel_q(chan), .vref_pos_ext_q(vpos), .vref_neg_ext_q(vneg),
    .pin_analog_cfg_q(pcfg), .conversion_done_flag_q(done));
  adcseq_analog_model #(.RC_DIV(RC_DIV)) u_front (.clk(clk), .vin(vin), .sar_code_q(code),
    .sample_switch_q(sw), .cmp_above(cmp), .rc_osc_tick(tick));

  task automatic conclude;
    if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask

  // One transfer; ready and the answer are sampled mid-cycle, where registered outputs are settled
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    logic ta, tw, fin;
    fin = 1'b0;
    @(posedge clk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= {3{w}};
    {arvalid, rready} <= {2{!w}};
    while (!fin) begin
      @(negedge clk);
      ta = w ? awready : arready;
      tw = wready;
      fin = w ? bvalid : rvalid;
      rd_q = rdata;
      resp_q = w ? bresp : rresp;
      @(posedge clk);
      if (ta) {awvalid, arvalid} <= 2'b00;
      if (tw) wvalid <= 1'b0;
    end
    {bready, rready} <= 2'b00;
  endtask

  task automatic chk_reset;
    logic [11:0] regs [4] = '{`ADCSEQ_ADDR_PRIMARY, `ADCSEQ_ADDR_PORTCFG,
      `ADCSEQ_ADDR_ACQ_CTRL, `ADCSEQ_ADDR_STATUS};
    for (int k = 0; k < 4; k++) begin
      xfer(1'b0, regs[k], 32'h0);
      chk(rd_q, 32'h0);
    end
    chk({31'h0, on}, 32'h0);
  endtask

  initial begin
    forever #20 clk = ~clk;
  end
  always @(negedge clk) cyc <= cyc + 1;
  initial begin
    #(40 * 60000);
    n_fail++;
    conclude;
  end

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    chk_reset;
    xfer(1'b1, `ADCSEQ_ADDR_STATUS, 32'h1);
    chk({30'h0, resp_q}, 32'h0);
    for (int i = 0; i < 8; i++) begin
      r = rows[i];
      vin <= r.vin;
      xfer(1'b1, `ADCSEQ_ADDR_PORTCFG, {25'h0, r.cs[2], i[1:0], i[3:0]});
      xfer(1'b1, `ADCSEQ_ADDR_PRIMARY, {24'h0, r.cs[1:0], i[2:0], 3'b001});
      xfer(1'b1, `ADCSEQ_ADDR_ACQ_CTRL, {24'h0, 2'b11, r.acq, 3'b111});
      xfer(1'b0, `ADCSEQ_ADDR_ACQ_CTRL, 32'h0);
      chk(rd_q, {26'h0, r.acq, 3'b000});
      chk({22'h0, vneg, vpos, pcfg, chan, on}, {22'h0, i[1:0], i[3:0], i[2:0], 1'b1});
      xfer(1'b1, `ADCSEQ_ADDR_PRIMARY, {24'h0, r.cs[1:0], i[2:0], 3'b101});
      t = cyc;
      xfer(1'b0, `ADCSEQ_ADDR_PRIMARY, 32'h0);
      chk({31'h0, rd_q[2]}, 32'h1);
      while (done !== 1'b1) @(posedge clk);
      t = cyc - t;
      // Divider rows end one clk after the last period; RC rows add the delay and tick alignment
      lo = (ACQ_BITS[r.acq] + 12) * r.bitp + ((r.bitp == RC_DIV) ? 5 : 1);
      hi = lo + ((r.bitp == RC_DIV) ? RC_DIV : 1);
      chk({31'h0, t >= lo && t <= hi}, 32'h1);
      xfer(1'b0, `ADCSEQ_ADDR_PRIMARY, 32'h0);
      chk(rd_q, {24'h0, r.cs[1:0], i[2:0], 3'b001});
      xfer(1'b0, `ADCSEQ_ADDR_RES_HIGH, 32'h0);
      chk(rd_q, {30'h0, r.vin[9:8]});
      xfer(1'b0, `ADCSEQ_ADDR_RES_LOW, 32'h0);
      chk(rd_q, {24'h0, r.vin[7:0]});
      chk({30'h0, resp_q}, 32'h0);
      xfer(1'b0, `ADCSEQ_ADDR_STATUS, 32'h0);
      chk(rd_q, 32'h1);
      xfer(1'b1, `ADCSEQ_ADDR_STATUS, 32'h1);
      chk({31'h0, done}, 32'h0);
      repeat (200) @(posedge clk);
    end
    xfer(1'b0, 12'h020, 32'h0);
    chk({30'h0, resp_q}, 32'h2);
    chk(rd_q, 32'h0);
    xfer(1'b1, 12'h020, 32'h0);
    chk({30'h0, resp_q}, 32'h2);
    // A write without the low byte lane must leave the register alone
    wstrb <= 4'h0;
    xfer(1'b1, `ADCSEQ_ADDR_ACQ_CTRL, 32'h0);
    wstrb <= 4'hf;
    xfer(1'b0, `ADCSEQ_ADDR_ACQ_CTRL, 32'h0);
    chk(rd_q, 32'h38);
    // 64 clk per bit and 20 bits of acquisition put the abort mid-conversion
    vin <= 10'h0f0;
    xfer(1'b1, `ADCSEQ_ADDR_PORTCFG, 32'h40);
    xfer(1'b1, `ADCSEQ_ADDR_PRIMARY, 32'h81);
    xfer(1'b1, `ADCSEQ_ADDR_PRIMARY, 32'h85);
    repeat (1600) @(posedge clk);
    xfer(1'b1, `ADCSEQ_ADDR_PRIMARY, 32'h81);
    repeat (1000) @(posedge clk);
    chk({31'h0, done}, 32'h0);
    xfer(1'b0, `ADCSEQ_ADDR_RES_LOW, 32'h0);
    chk(rd_q, 32'hfe);
    xfer(1'b1, `ADCSEQ_ADDR_PRIMARY, 32'h85);
    repeat (1600) @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    chk_reset;
    xfer(1'b0, `ADCSEQ_ADDR_RES_HIGH, 32'h0);
    chk(rd_q, 32'h3);
    conclude;
  end
endmodule // tb_adcseq_top

bind adcseq_top adcseq_top_asserts u_chk (.clk(clk), .rst_n(rst_n),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .sample_switch_q(sample_switch_q), .converter_on_q(converter_on_q),
  .conversion_done_flag_q(conversion_done_flag_q));
`default_nettype wire
